// [design/usc_pkg.sv]
package usc_pkg;
   // operating mode field codes
   localparam logic [1:0] MODE_ASYNC = 2'h0;
   localparam logic [1:0] MODE_SYNC  = 2'h1;
   localparam logic [1:0] MODE_SPI   = 2'h3;
   // oversampling, last sample counter value of a bit
   localparam logic [3:0] OS_LAST_NORMAL = 4'hf;
   localparam logic [3:0] OS_LAST_DOUBLE = 4'h7;
   // majority vote window, zero-based sample counter
   localparam logic [3:0] VOTE_FIRST_NORMAL = 4'h7;
   localparam logic [3:0] VOTE_LAST_NORMAL  = 4'h9;
   localparam logic [3:0] VOTE_FIRST_DOUBLE = 4'h3;
   localparam logic [3:0] VOTE_LAST_DOUBLE  = 4'h5;
   // sample counter value right after start detection
   localparam logic [3:0] OS_AFTER_DETECT = 4'h1;
   // data length field decoding
   localparam logic [2:0] LEN_CODE_NINE = 3'h7;
   localparam logic [3:0] LEN_BASE      = 4'h5;
   localparam logic [3:0] LEN_NINE      = 4'h9;
   // transmit frame image: start, 9 data, parity, 2 stop
   localparam int FRAME_W = 13;
   // receive buffer entry layout
   localparam int ENT_W     = 12;
   localparam int ENT_NINTH = 8;
   localparam int ENT_FE    = 9;
   localparam int ENT_DOR   = 10;
   localparam int ENT_PE    = 11;
   // flag reset values
   localparam logic DRE_RESET = 1'b1;
   localparam logic TXC_RESET = 1'b0;
   // state machines
   typedef enum logic [1:0] {
      TX_IDLE  = 2'b01,
      TX_SHIFT = 2'b10
   } usc_tx_state_t;
   typedef enum logic [1:0] {
      RX_IDLE  = 2'b01,
      RX_FRAME = 2'b10
   } usc_rx_state_t;
endpackage : usc_pkg

// [design/usc_baud_gen.sv]
`timescale 1ns/10ps
module usc_baud_gen #(
   parameter int BAUD_W = 8
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // divisor, period is divisor plus one
   input  wire logic [BAUD_W-1:0] i_divisor,
   // one-cycle enable at fx / (divisor + 1)
   output logic                   o_tick
);
   logic [BAUD_W-1:0] cnt_r;

   // divide-by-(n+1) counter
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         cnt_r  <= '0;
         o_tick <= 1'b0;
      end
      else if (cnt_r >= i_divisor)
      begin
         cnt_r  <= '0;
         o_tick <= 1'b1;
      end
      else
      begin
         cnt_r  <= cnt_r + 1'b1;
         o_tick <= 1'b0;
      end
   end

   // divisor one gives a tick every second cycle
   property p_tick_gap;
      @(posedge i_clk) disable iff (i_rst)
      o_tick && i_divisor == 1 && $stable(i_divisor)
         |=> !o_tick ##1 o_tick;
   endproperty
   a_tick_gap: assert property (p_tick_gap)
      else $error("baud tick spacing wrong");
endmodule : usc_baud_gen

// [design/usc_core.sv]
`timescale 1ns/10ps
// Summary of operation
// - async normal rate is fx over 16 times divisor plus one
// - async double speed rate is fx over 8 times divisor plus one
// - sync master clock is fx over 2 times divisor plus one
// - mode picks async or sync; master drives clock pin, slave takes it
// - slave clock passes synchroniser and edge detector, three cycle delay
// - sync data changes on one clock edge, sampled on the other
// - frame: start, 5 to 9 data, optional parity, 1 or 2 stops
// - data least significant bit first, parity before first stop
// - line idles high, falling edge marks start, frames may abut
// - transmitter and receiver share one frame setting
// - even parity is xor of data, odd parity is its inverse
// - transmit disable waits for frame end, then pin released
// - data write fills buffer, moved to shifter when idle or at end
// - empty flag tracks buffer; writing zero clears it
// - empty interrupt while flag, its enable and global enable set
// - complete flag when frame out and buffer empty; ack or zero clears
// - complete interrupt while flag, its enable and global enable set
// - receiver starts on low start bit, shifts to first stop only
// - first stop bit moves shifter contents into receive buffer
// - nine-bit frames keep received ninth bit apart, read it first
// - error flags travel with each receive buffer entry
// - async receiver oversamples 16 or 8, votes samples 8 to 10 (4 to 6 at double speed)
// - complete flag shows unread data; receiver disable flushes
// - overrun when buffer full and new frame ends; data then lost
// - frame error when first stop bit sampled low
module usc_core #(
   parameter int BAUD_W = 8
) (
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_rst,
   // mode and clock setup
   input  wire logic [1:0]        i_op_mode_select,
   input  wire logic              i_double_speed_bit,
   input  wire logic              i_clock_master_bit,
   input  wire logic              i_clock_polarity_bit,
   input  wire logic [BAUD_W-1:0] i_baud_divisor,
   // frame format
   input  wire logic [2:0]        i_data_length_field,
   input  wire logic [1:0]        i_parity_mode_field,
   input  wire logic              i_stop_bit_count_bit,
   // enables
   input  wire logic              i_transmit_enable_bit,
   input  wire logic              i_receive_enable_bit,
   input  wire logic              i_tx_empty_irq_enable,
   input  wire logic              i_tx_complete_irq_enable,
   input  wire logic              i_global_irq_enable,
   // data register and flag writes
   input  wire logic              i_data_wr,
   input  wire logic [7:0]        i_data_wdata,
   input  wire logic              i_transmit_ninth_bit,
   input  wire logic              i_data_rd,
   input  wire logic              i_tx_empty_clr,
   input  wire logic              i_tx_complete_clr,
   input  wire logic              i_tx_complete_ack,
   // receive buffer head and status
   output logic [7:0]             o_rx_data,
   output logic                   o_receive_ninth_bit,
   output logic                   o_frame_error_flag,
   output logic                   o_overrun_flag,
   output logic                   o_parity_error_flag,
   output logic                   o_rx_complete_flag,
   output logic                   o_tx_buffer_empty_flag,
   output logic                   o_tx_complete_flag,
   output logic                   o_tx_empty_irq,
   output logic                   o_tx_complete_irq,
   // pins
   input  wire logic              i_receive_pin,
   output logic                   o_transmit_pin,
   output logic                   o_transmit_pin_oe,
   input  wire logic              i_serial_clock_pin,
   output logic                   o_serial_clock_pin,
   output logic                   o_serial_clock_pin_oe
);
   localparam int FW = usc_pkg::FRAME_W;

   // xor of the first n data bits, inverted for odd
   function automatic logic data_parity(input logic [8:0] d,
                                        input logic [3:0] n,
                                        input logic       odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++)
         if (i < int'(n))
            p = p ^ d[i];
      return p;
   endfunction : data_parity

   // start, data lsb first, parity, stop ones
   function automatic logic [FW-1:0] build_frame(input logic [8:0] d,
                                                 input logic [3:0] n,
                                                 input logic       pe,
                                                 input logic       odd);
      logic [FW-1:0] f;
      f    = '1;
      f[0] = 1'b0;
      for (int i = 0; i < 9; i++)
         if (i < int'(n))
            f[i+1] = d[i];
      if (pe)
         f[int'(n)+1] = data_parity(d, n, odd);
      return f;
   endfunction : build_frame

   // shared frame setting
   logic       sync_mode, par_en, par_odd;
   logic [3:0] nbits, frame_len, os_last, vote_first, vote_last;
   assign sync_mode = i_op_mode_select != usc_pkg::MODE_ASYNC;
   assign nbits     = i_data_length_field[2] ? usc_pkg::LEN_NINE
                    : usc_pkg::LEN_BASE + {2'h0, i_data_length_field[1:0]};
   assign par_en    = i_parity_mode_field[1];
   assign par_odd   = i_parity_mode_field[0];
   assign frame_len = 4'h1 + nbits + {3'h0, par_en}
                    + (i_stop_bit_count_bit ? 4'h2 : 4'h1);
   assign os_last    = i_double_speed_bit ? usc_pkg::OS_LAST_DOUBLE
                                          : usc_pkg::OS_LAST_NORMAL;
   assign vote_first = i_double_speed_bit ? usc_pkg::VOTE_FIRST_DOUBLE
                                          : usc_pkg::VOTE_FIRST_NORMAL;
   assign vote_last  = i_double_speed_bit ? usc_pkg::VOTE_LAST_DOUBLE
                                          : usc_pkg::VOTE_LAST_NORMAL;

   // base rate fx / (divisor + 1)
   logic baud_tick;
   usc_baud_gen #(.BAUD_W(BAUD_W)) u_baud (
      .i_clk     (i_clk),
      .i_rst     (i_rst),
      .i_divisor (i_baud_divisor),
      .o_tick    (baud_tick)
   );

   // pin synchronisers, level taken once stages two and three agree
   logic [2:0] sck_sync_r, rxd_sync_r;
   logic       sck_lvl_r, rxd_lvl_r;
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sck_sync_r <= '0;
         rxd_sync_r <= 3'h7;
         sck_lvl_r  <= 1'b0;
         rxd_lvl_r  <= 1'b1;
      end
      else
      begin
         sck_sync_r <= {sck_sync_r[1:0], i_serial_clock_pin};
         rxd_sync_r <= {rxd_sync_r[1:0], i_receive_pin};
         if (sck_sync_r[2] == sck_sync_r[1])
            sck_lvl_r <= sck_sync_r[2];
         if (rxd_sync_r[2] == rxd_sync_r[1])
            rxd_lvl_r <= rxd_sync_r[2];
      end
   end

   // transmitter and buffer state
   usc_pkg::usc_tx_state_t tx_st_r, tx_st_nxt;
   logic [FW-1:0] frame_r, frame_nxt;
   logic [3:0]    tx_cnt_r, tx_cnt_nxt, tx_os_r;
   logic [8:0]    tbuf_r;
   logic          tbuf_full_r, tx_bit_en, tx_load, tx_frame_end;

   // serial clock edges, polarity folded out
   logic mclk_r, mclk_nxt, sck_run, s_stable, s_new, s_old;
   logic shift_edge, sample_edge;
   assign sck_run  = sync_mode && i_clock_master_bit
                   && (tx_st_r == usc_pkg::TX_SHIFT || mclk_r
                       || (tbuf_full_r && i_transmit_enable_bit));
   assign mclk_nxt = (sck_run && baud_tick) ? !mclk_r : mclk_r;
   assign s_stable = sck_sync_r[2] == sck_sync_r[1];
   assign s_new    = sck_sync_r[2] ^ i_clock_polarity_bit;
   assign s_old    = sck_lvl_r ^ i_clock_polarity_bit;
   // edge detector on the synchronised slave clock
   assign shift_edge  = i_clock_master_bit ? (sck_run && baud_tick && !mclk_r)
                      : (s_stable && s_new && !s_old);
   assign sample_edge = i_clock_master_bit ? (sck_run && baud_tick && mclk_r)
                      : (s_stable && !s_new && s_old);

   // master clock drive, pin only active in synchronous modes
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         mclk_r                <= 1'b0;
         o_serial_clock_pin    <= 1'b0;
         o_serial_clock_pin_oe <= 1'b0;
      end
      else
      begin
         mclk_r                <= mclk_nxt;
         o_serial_clock_pin    <= mclk_nxt ^ i_clock_polarity_bit;
         o_serial_clock_pin_oe <= sync_mode && i_clock_master_bit;
      end
   end

   // transmit bit pacing
   assign tx_bit_en = sync_mode ? shift_edge
                    : (baud_tick && tx_os_r == os_last);
   assign tx_frame_end = tx_bit_en && tx_st_r == usc_pkg::TX_SHIFT
                       && tx_cnt_r == 4'h1;
   assign tx_load = tx_bit_en && tbuf_full_r && i_transmit_enable_bit
                  && (tx_st_r == usc_pkg::TX_IDLE || tx_cnt_r == 4'h1);

   // next transmit state
   always_comb
   begin
      tx_st_nxt  = tx_st_r;
      frame_nxt  = frame_r;
      tx_cnt_nxt = tx_cnt_r;
      if (tx_load)
      begin
         tx_st_nxt  = usc_pkg::TX_SHIFT;
         frame_nxt  = build_frame(tbuf_r, nbits, par_en, par_odd);
         tx_cnt_nxt = frame_len;
      end
      else if (tx_frame_end)
         tx_st_nxt = usc_pkg::TX_IDLE;
      else if (tx_st_r == usc_pkg::TX_SHIFT && tx_bit_en)
      begin
         frame_nxt  = {1'b1, frame_r[FW-1:1]};
         tx_cnt_nxt = tx_cnt_r - 4'h1;
      end
   end

   // transmit shifter and pin
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tx_st_r           <= usc_pkg::TX_IDLE;
         frame_r           <= '1;
         tx_cnt_r          <= 4'h0;
         tx_os_r           <= 4'h0;
         o_transmit_pin    <= 1'b1;
         o_transmit_pin_oe <= 1'b0;
      end
      else
      begin
         tx_st_r  <= tx_st_nxt;
         frame_r  <= frame_nxt;
         tx_cnt_r <= tx_cnt_nxt;
         if (baud_tick)
            tx_os_r <= (tx_os_r >= os_last) ? 4'h0 : tx_os_r + 4'h1;
         o_transmit_pin    <= (tx_st_nxt == usc_pkg::TX_SHIFT)
                            ? frame_nxt[0] : 1'b1;
         o_transmit_pin_oe <= i_transmit_enable_bit
                            || tx_st_nxt == usc_pkg::TX_SHIFT;
      end
   end

   // transmit buffer, ninth bit caught with the low byte
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         tbuf_r      <= 9'h000;
         tbuf_full_r <= 1'b0;
      end
      else
      begin
         if (i_data_wr)
            tbuf_r <= {i_transmit_ninth_bit, i_data_wdata};
         tbuf_full_r <= i_data_wr || (tbuf_full_r && !tx_load);
      end
   end

   // transmit flags and interrupt requests, set wins over clear, but a data write clears the empty flag even in a load cycle
   logic dre_nxt, txc_nxt;
   always_comb
   begin
      dre_nxt = o_tx_buffer_empty_flag;
      if (i_data_wr)
         dre_nxt = 1'b0;
      else if (tx_load)
         dre_nxt = 1'b1;
      else if (i_tx_empty_clr)
         dre_nxt = 1'b0;
      txc_nxt = o_tx_complete_flag;
      if (tx_frame_end && !tbuf_full_r)
         txc_nxt = 1'b1;
      else if (i_tx_complete_clr || i_tx_complete_ack)
         txc_nxt = 1'b0;
   end
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_tx_buffer_empty_flag <= usc_pkg::DRE_RESET;
         o_tx_complete_flag     <= usc_pkg::TXC_RESET;
         o_tx_empty_irq         <= 1'b0;
         o_tx_complete_irq      <= 1'b0;
      end
      else
      begin
         o_tx_buffer_empty_flag <= dre_nxt;
         o_tx_complete_flag     <= txc_nxt;
         o_tx_empty_irq    <= dre_nxt && i_tx_empty_irq_enable
                           && i_global_irq_enable;
         o_tx_complete_irq <= txc_nxt && i_tx_complete_irq_enable
                           && i_global_irq_enable;
      end
   end

   // receiver bit recovery
   usc_pkg::usc_rx_state_t rx_st_r;
   logic [3:0] rx_os_r, rx_idx_r, stop_idx;
   logic [1:0] vote_r;
   logic [8:0] rdata_r;
   logic       rpar_r, rx_start, rx_bit_ev, rx_bit_val, rx_store;
   assign stop_idx  = nbits + 4'h1 + {3'h0, par_en};
   assign rx_start  = rx_st_r == usc_pkg::RX_IDLE && i_receive_enable_bit
                    && !rxd_lvl_r && (sync_mode ? sample_edge : baud_tick);
   assign rx_bit_ev = rx_st_r == usc_pkg::RX_FRAME
                    && (sync_mode ? sample_edge
                        : (baud_tick && rx_os_r == vote_last));
   assign rx_bit_val = sync_mode ? rxd_lvl_r
                     : ((vote_r[1] & vote_r[0]) | (vote_r[1] & rxd_lvl_r)
                        | (vote_r[0] & rxd_lvl_r));
   assign rx_store  = rx_bit_ev && rx_idx_r == stop_idx;

   // receive frame sequencer
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         rx_st_r  <= usc_pkg::RX_IDLE;
         rx_os_r  <= 4'h0;
         rx_idx_r <= 4'h0;
         vote_r   <= 2'h3;
         rdata_r  <= 9'h000;
         rpar_r   <= 1'b0;
      end
      else if (!i_receive_enable_bit)
         rx_st_r <= usc_pkg::RX_IDLE;
      else if (rx_start)
      begin
         rx_st_r  <= usc_pkg::RX_FRAME;
         rx_os_r  <= usc_pkg::OS_AFTER_DETECT;
         rx_idx_r <= sync_mode ? 4'h1 : 4'h0;
         rdata_r  <= 9'h000;
      end
      else if (rx_st_r == usc_pkg::RX_FRAME)
      begin
         if (baud_tick)
         begin
            rx_os_r <= (rx_os_r >= os_last) ? 4'h0 : rx_os_r + 4'h1;
            if (rx_os_r >= vote_first && rx_os_r < vote_last)
               vote_r <= {vote_r[0], rxd_lvl_r};
         end
         if (rx_bit_ev)
         begin
            rx_idx_r <= rx_idx_r + 4'h1;
            if (rx_idx_r == 4'h0 && rx_bit_val)
               rx_st_r <= usc_pkg::RX_IDLE; // false start
            else if (rx_idx_r != 4'h0 && rx_idx_r <= nbits)
               rdata_r[rx_idx_r - 4'h1] <= rx_bit_val;
            else if (par_en && rx_idx_r == nbits + 4'h1)
               rpar_r <= rx_bit_val;
            if (rx_store)
               rx_st_r <= usc_pkg::RX_IDLE;
         end
      end
   end

   // two-entry receive buffer, flags held per entry
   logic [usc_pkg::ENT_W-1:0] ent_r [2];
   logic [usc_pkg::ENT_W-1:0] new_ent;
   logic [1:0]                rx_cnt_r;
   logic                      rd_ptr_r, rx_pop, rx_push, rx_overrun;
   assign rx_pop     = i_data_rd && rx_cnt_r != 2'h0;
   assign rx_push    = rx_store && (rx_cnt_r != 2'h2 || rx_pop);
   assign rx_overrun = rx_store && !rx_push;
   assign new_ent = {par_en && data_parity(rdata_r, nbits, par_odd) != rpar_r,
                     1'b0, !rx_bit_val,
                     (i_data_length_field == usc_pkg::LEN_CODE_NINE)
                        && rdata_r[8], rdata_r[7:0]};
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         ent_r    <= '{default: '0};
         rx_cnt_r <= 2'h0;
         rd_ptr_r <= 1'b0;
      end
      else if (!i_receive_enable_bit)
      begin
         rx_cnt_r <= 2'h0;
         rd_ptr_r <= 1'b0;
      end
      else
      begin
         if (rx_push)
            ent_r[rd_ptr_r ^ rx_cnt_r[0]] <= new_ent;
         else if (rx_overrun)
            ent_r[!rd_ptr_r][usc_pkg::ENT_DOR] <= 1'b1;
         if (rx_pop)
            rd_ptr_r <= !rd_ptr_r;
         rx_cnt_r <= rx_cnt_r + {1'b0, rx_push} - {1'b0, rx_pop};
      end
   end

   // receive head shown to software
   always_ff @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_rx_data           <= 8'h00;
         o_receive_ninth_bit <= 1'b0;
         o_frame_error_flag  <= 1'b0;
         o_overrun_flag      <= 1'b0;
         o_parity_error_flag <= 1'b0;
         o_rx_complete_flag  <= 1'b0;
      end
      else
      begin
         o_rx_data           <= ent_r[rd_ptr_r][7:0];
         o_receive_ninth_bit <= ent_r[rd_ptr_r][usc_pkg::ENT_NINTH];
         o_frame_error_flag  <= ent_r[rd_ptr_r][usc_pkg::ENT_FE];
         o_overrun_flag      <= ent_r[rd_ptr_r][usc_pkg::ENT_DOR];
         o_parity_error_flag <= ent_r[rd_ptr_r][usc_pkg::ENT_PE];
         o_rx_complete_flag  <= rx_cnt_r != 2'h0;
      end
   end

   property p_rate_normal;
      @(posedge i_clk) disable iff (i_rst)
      tx_st_r == usc_pkg::TX_SHIFT && tx_bit_en && !sync_mode
         && !i_double_speed_bit && i_baud_divisor == 0
         |=> (!tx_bit_en) [*8] ##1 (!tx_bit_en) [*7] ##1 tx_bit_en;
   endproperty
   a_rate_normal: assert property (p_rate_normal)
      else $error("normal bit pace not sixteen ticks");
   property p_rate_double;
      @(posedge i_clk) disable iff (i_rst)
      tx_st_r == usc_pkg::TX_SHIFT && tx_bit_en && !sync_mode
         && i_double_speed_bit && i_baud_divisor == 1
         |=> (!tx_bit_en) [*8] ##1 (!tx_bit_en) [*7] ##1 tx_bit_en;
   endproperty
   a_rate_double: assert property (p_rate_double)
      else $error("double speed bit pace not eight ticks");
   property p_master_toggle;
      @(posedge i_clk) disable iff (i_rst)
      sck_run && baud_tick && !i_clock_polarity_bit ##1
         !i_clock_polarity_bit |-> o_serial_clock_pin != $past(mclk_r);
   endproperty
   a_master_toggle: assert property (p_master_toggle)
      else $error("master clock did not toggle on tick");
   property p_idle_high;
      @(posedge i_clk) disable iff (i_rst)
      tx_st_r == usc_pkg::TX_IDLE && !tx_load |=> o_transmit_pin;
   endproperty
   a_idle_high: assert property (p_idle_high)
      else $error("idle transmit line not high");
   property p_oe_off;
      @(posedge i_clk) disable iff (i_rst)
      !i_transmit_enable_bit && tx_st_r == usc_pkg::TX_IDLE
         |=> !o_transmit_pin_oe;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("transmit pin held after disable");
   property p_dre_fill;
      @(posedge i_clk) disable iff (i_rst)
      i_data_wr |=> !o_tx_buffer_empty_flag;
   endproperty
   a_dre_fill: assert property (p_dre_fill)
      else $error("empty flag set after data write");
   property p_txc_set;
      @(posedge i_clk) disable iff (i_rst)
      tx_frame_end && !tbuf_full_r |=> o_tx_complete_flag;
   endproperty
   a_txc_set: assert property (p_txc_set)
      else $error("complete flag missed at frame end");
   property p_dre_irq;
      @(posedge i_clk) disable iff (i_rst)
      o_tx_empty_irq |-> o_tx_buffer_empty_flag && $past(i_global_irq_enable);
   endproperty
   a_dre_irq: assert property (p_dre_irq)
      else $error("empty interrupt without its flag");
   property p_flush;
      @(posedge i_clk) disable iff (i_rst)
      !i_receive_enable_bit ##1 !i_receive_enable_bit |=> !o_rx_complete_flag;
   endproperty
   a_flush: assert property (p_flush)
      else $error("receive buffer not flushed on disable");
   property p_store;
      @(posedge i_clk) disable iff (i_rst)
      rx_store && rx_cnt_r == 2'h0 && i_receive_enable_bit
         |=> rx_cnt_r == 2'h1 ##1 o_rx_complete_flag;
   endproperty
   a_store: assert property (p_store)
      else $error("stop bit did not fill receive buffer");
endmodule : usc_core

// [bench/usc_remote.sv]
`timescale 1ns/10ps
// remote async transceiver, fixed bit time in clocks
module usc_remote #(
   parameter int BIT_T = 16
) (
   input  wire logic        i_clk,
   input  wire logic        i_line,
   output logic             o_line,
   output logic [11:0]      o_cap
);
   // start low, nb bits lsb first, one stop high
   task automatic send(input logic [11:0] f, input int nb);
      for (int i = -1; i <= nb; i++)
      begin
         o_line <= (i < 0) ? 1'b0 : (i == nb) ? 1'b1 : f[i];
         repeat (BIT_T) @(posedge i_clk);
      end
   endtask : send
   initial o_line = 1'b1;
   // capture 12 bit slots after a start edge, mid-bit
   always
   begin
      @(negedge i_line);
      repeat (BIT_T / 2) @(posedge i_clk);
      for (int n = 0; n < 12; n++)
      begin
         repeat (BIT_T) @(posedge i_clk);
         o_cap[n] <= i_line;
      end
   end
endmodule : usc_remote

// [bench/usc_core_test.sv]
`timescale 1ns/10ps
// formats sent both ways through a remote end
module usc_core_test;
   logic i_clk = 0, i_rst = 1, i_double_speed_bit = 0, i_data_wr = 0;
   logic i_data_rd = 0, i_tx_complete_clr = 0, i_tx_complete_ack = 0;
   logic i_transmit_ninth_bit = 0, i_stop_bit_count_bit = 0;
   logic i_transmit_enable_bit = 1, i_receive_enable_bit = 1;
   logic i_tx_empty_irq_enable = 1, i_tx_complete_irq_enable = 1;
   logic i_global_irq_enable = 1, i_tx_empty_clr = 0;
   logic i_serial_clock_pin = 0;
   logic i_clock_master_bit = 0, i_clock_polarity_bit = 0, i_receive_pin;
   logic [1:0] i_op_mode_select = 2'h0, i_parity_mode_field = 2'h0, pm;
   logic [2:0] i_data_length_field = 3'h0, c;
   logic [7:0] i_baud_divisor = 8'h00, i_data_wdata = 8'h00, o_rx_data;
   logic o_receive_ninth_bit, o_frame_error_flag, o_overrun_flag;
   logic o_parity_error_flag, o_rx_complete_flag, o_tx_buffer_empty_flag;
   logic o_tx_complete_flag, o_tx_empty_irq, o_tx_complete_irq;
   logic o_transmit_pin, o_transmit_pin_oe, o_serial_clock_pin;
   logic o_serial_clock_pin_oe;
   logic [11:0] cap;
   logic [8:0] d;
   int error_cnt = 0, checked = 0, nb, t;
   // released transmit line is pulled high
   wire logic txl = o_transmit_pin_oe ? o_transmit_pin : 1'b1;
   usc_core uut (.*);
   usc_remote rem (.i_clk(i_clk), .i_line(txl), .o_line(i_receive_pin),
                   .o_cap(cap));
   always #20 i_clk = ~i_clk;
   // compare and count
   task automatic chk(input string nm, input logic [11:0] e, g);
      checked++;
      if (g !== e)
      begin
         error_cnt++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // expected bits after start: data lsb first, parity, then ones
   function automatic logic [11:0] frm(input logic [8:0] v, input int n,
                                       input logic [1:0] m);
      logic [11:0] f;
      logic        p;
      f = 12'hfff;
      p = m[0];
      for (int i = 0; i < n; i++)
      begin
         f[i] = v[i];
         p = p ^ v[i];
      end
      if (m[1])
         f[n] = p;
      return f;
   endfunction : frm
   task automatic tally_and_finish;
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : tally_and_finish
   // watchdog
   initial
   begin
      #2000000;
      error_cnt++;
      tally_and_finish();
   end
   // all thirty formats, bit time 16 in both speed modes
   initial
   begin
      void'($urandom(32'h25f1));
      repeat (10) @(posedge i_clk);
      i_rst <= 0;
      for (int k = 0; k < 30; k++)
      begin
         c = (k % 5 == 4) ? 3'h7 : 3'(k % 5);
         nb = (c == 3'h7) ? 9 : k % 5 + 5;
         pm = (k / 5 % 3 == 0) ? 2'h0 : 2'(k / 5 % 3 + 1);
         d = 9'($urandom);
         @(posedge i_clk);
         i_data_length_field <= c;
         i_parity_mode_field <= pm;
         i_stop_bit_count_bit <= 1'(k / 15);
         i_double_speed_bit <= k[0];
         i_baud_divisor <= {7'h0, k[0]};
         i_data_wdata <= d[7:0];
         i_transmit_ninth_bit <= d[8];
         i_data_wr <= 1'b1;
         @(posedge i_clk);
         i_data_wr <= 1'b0;
         #1 chk("empty", 0, o_tx_buffer_empty_flag);
         for (t = 0; t < 400 && o_tx_complete_flag !== 1'b1; t++)
            @(posedge i_clk);
         #1 chk("txc_irq", 1, o_tx_complete_irq);
         chk("dre_irq", 1, o_tx_empty_irq);
         repeat (208) @(posedge i_clk);
         chk("frame", frm(d, nb, pm), cap);
         if (k[0])
         begin
            i_tx_complete_ack <= 1'b1;
            i_tx_empty_clr <= 1'b1;
         end
         else
            i_tx_complete_clr <= 1'b1;
         @(posedge i_clk);
         i_tx_complete_ack <= 1'b0;
         i_tx_complete_clr <= 1'b0;
         i_tx_empty_clr <= 1'b0;
         @(posedge i_clk);
         #1 chk("txc", 0, o_tx_complete_flag);
         chk("dre_clr", !k[0], o_tx_buffer_empty_flag);
         chk("dre_irq_off", !k[0], o_tx_empty_irq);
         rem.send(frm(d, nb, pm), nb + int'(pm[1]));
         repeat (4) @(posedge i_clk);
         chk("rxc", 1, o_rx_complete_flag);
         chk("rxd", d[7:0] & 8'((1 << nb) - 1), o_rx_data);
         chk("rx9", (c == 3'h7) & d[8], o_receive_ninth_bit);
         chk("pe", 0, o_parity_error_flag);
         chk("fe", 0, o_frame_error_flag);
         i_data_rd <= 1'b1;
         @(posedge i_clk);
         i_data_rd <= 1'b0;
         repeat (3) @(posedge i_clk);
         chk("rxc_pop", 0, o_rx_complete_flag);
      end
      // low first stop bit, entry left unread in the buffer
      rem.send(frm(d, 9, pm) & 12'hbff, 11);
      chk("fe_bad", 1, o_frame_error_flag);
      // bad parity frame fills buffer, third frame overruns
      rem.send(frm(d, 9, pm) ^ 12'h200, 11);
      rem.send(frm(d, 9, pm), 11);
      i_data_rd <= 1'b1;
      @(posedge i_clk);
      i_data_rd <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk("pe_bad", 1, o_parity_error_flag);
      chk("dor", 1, o_overrun_flag);
      i_receive_enable_bit <= 1'b0;
      i_transmit_enable_bit <= 1'b0;
      repeat (3) @(posedge i_clk);
      chk("flush", 0, o_rx_complete_flag);
      chk("tx_oe", 0, o_transmit_pin_oe);
      // synchronous master transmit, clock pin driven
      i_op_mode_select <= 2'h1;
      i_clock_master_bit <= 1'b1;
      i_transmit_enable_bit <= 1'b1;
      i_data_wr <= 1'b1;
      @(posedge i_clk);
      i_data_wr <= 1'b0;
      repeat (80) @(posedge i_clk);
      chk("sck_oe", 1, o_serial_clock_pin_oe);
      chk("sck_idle", 0, o_serial_clock_pin);
      chk("sync_txc", 1, o_tx_complete_flag);
      tally_and_finish();
   end
endmodule : usc_core_test
